// ===== system_clock_distribution.sv
// chip clock distribution, reset pin and debug mode entry
// assumes all clock sources and pins are asynchronous levels sampled by I_SYS_CLK;
// lvd, internal reset and debug command inputs come from logic on I_SYS_CLK
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module system_clock_distribution
    import clock_dist_pkg::*;
#(
    parameter int RST_PULSE_CYC = RST_PULSE_BUS_CYC
)(
    // clock and reset
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RSTN,
    // register port
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [DATA_W-1:0] I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic      [DATA_W-1:0] O_RDATA,
    // clock sources
    input  wire logic              I_INT_REF_CLK,
    input  wire logic              I_EXT_REF_CLK,
    input  wire logic              I_FLL_CLK,
    input  wire logic              I_CONTROLLED_OSCILLATOR,
    input  wire logic              I_FIXED_FREQ_PRESYNC,
    input  wire logic              I_LOW_POWER_OSC_CLOCK,
    input  wire logic              I_CRYSTAL_OSC_OUTPUT,
    input  wire logic              I_TIMER_EXT_CLOCK,
    // reset sources
    input  wire logic              I_LVD_RESET,
    input  wire logic              I_INTERNAL_RESET_REQ,
    input  wire logic              I_DEBUG_CMD_ACTIVE,
    // pins
    input  wire logic              I_MODE_SELECT_PIN,
    input  wire logic              I_PORT_A_BIT_FIVE,
    output logic                   O_PORT_A_BIT_FIVE_O,
    output logic                   O_PORT_A_BIT_FIVE_OE,
    output logic                   O_RESET_PULLUP_EN,
    output logic                   O_IRQ_PULLUP_EN,
    output logic                   O_GPIO_IN,
    // distributed clocks
    output logic                   O_CORE_CLOCK_SOURCE,
    output logic                   O_PERIPHERAL_BUS_CLOCK,
    output logic                   O_DEBUG_FAST_CLOCK,
    output logic                   O_EXT_REF_CLOCK_OUT,
    output logic                   O_INT_REF_CLOCK_OUT,
    output logic                   O_FIXED_FREQ_CLOCK,
    output logic                   O_LOW_POWER_OSC_CLOCK,
    output logic                   O_CRYSTAL_OSC_OUTPUT,
    output logic                   O_TIMER_EXT_CLOCK,
    // mode and system reset
    output logic                   O_BACKGROUND_DEBUG_MODE,
    output logic                   O_SYS_RESET_N
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin : g_bad_pulse
        $error("RST_PULSE_CYC must be 1..255");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    clk_src_e         sel_req_q;
    clk_src_e         sel_q;
    logic             core_q;
    logic             core_prev_q;
    logic             bus_q;
    logic             core_rise;
    logic             bus_tick;
    logic             irq_pu_q;
    logic             irq_fn_q;
    logic             rst_pin_en_q;
    logic [4:0]       cause_q;
    logic             bdm_q;
    rst_state_e       state_q;
    rst_state_e       state_d;
    logic [7:0]       cnt_q;
    logic [7:0]       cnt_d;
    logic             req_pin;
    logic             req_force;
    logic             req_any;
    logic [7:0]       hcnt_q;

    // picks the waveform of one core source from the synchronised lanes
    function automatic logic pick_src(input clk_src_e s, input logic [NSYNC-1:0] v);
        case (s)
            SRC_FLL:     pick_src = v[SY_FLL];
            SRC_INT_REF: pick_src = v[SY_INT_REF];
            SRC_EXT_REF: pick_src = v[SY_EXT_REF];
            default:     pick_src = 1'b0;
        endcase
    endfunction : pick_src

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    assign async_in = {I_PORT_A_BIT_FIVE, I_MODE_SELECT_PIN, I_TIMER_EXT_CLOCK,
                       I_CRYSTAL_OSC_OUTPUT, I_LOW_POWER_OSC_CLOCK, I_FIXED_FREQ_PRESYNC,
                       I_CONTROLLED_OSCILLATOR, I_EXT_REF_CLK, I_INT_REF_CLK, I_FLL_CLK};

    // two flops per lane; pin lanes reset high to match the pullups
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            meta_q <= 10'h300;
            sync_q <= 10'h300;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    // ----------------------------------------------------------------
    // core clock selection and bus divider
    // ----------------------------------------------------------------
    // switch only while both old and new source sit low, so no runt pulse reaches the core
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            sel_q <= SRC_FLL;
        end else if (sel_req_q != sel_q && sel_req_q != SRC_NONE && !core_q
                     && !pick_src(sel_req_q, sync_q)) begin
            sel_q <= sel_req_q;                                  // R2 R18
        end
    end

    assign core_rise = core_q & ~core_prev_q;
    assign bus_tick  = core_rise & ~bus_q;

    // bus clock toggles only on core rising edges, keeping both in phase
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            core_q      <= 1'b0;
            core_prev_q <= 1'b0;
            bus_q       <= 1'b0;
        end else begin
            core_q      <= pick_src(sel_q, sync_q);              // R1
            core_prev_q <= core_q;
            if (core_rise) begin
                bus_q <= ~bus_q;                                 // R1 R18
            end
        end
    end

    // ----------------------------------------------------------------
    // distributed clocks
    // ----------------------------------------------------------------
    // the fixed clock is only usable after sampling; ratio to bus is software's job
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            O_CORE_CLOCK_SOURCE    <= 1'b0;
            O_PERIPHERAL_BUS_CLOCK <= 1'b0;
            O_DEBUG_FAST_CLOCK     <= 1'b0;
            O_EXT_REF_CLOCK_OUT    <= 1'b0;
            O_INT_REF_CLOCK_OUT    <= 1'b0;
            O_FIXED_FREQ_CLOCK     <= 1'b0;
            O_LOW_POWER_OSC_CLOCK  <= 1'b0;
            O_CRYSTAL_OSC_OUTPUT   <= 1'b0;
            O_TIMER_EXT_CLOCK      <= 1'b0;
        end else begin
            O_CORE_CLOCK_SOURCE    <= core_q;                    // R1
            O_PERIPHERAL_BUS_CLOCK <= bus_q;                     // R3
            O_DEBUG_FAST_CLOCK     <= sync_q[SY_OSC] & (sel_q != SRC_FLL); // R5
            O_EXT_REF_CLOCK_OUT    <= sync_q[SY_EXT_REF];        // R6
            O_INT_REF_CLOCK_OUT    <= sync_q[SY_INT_REF];        // R7
            O_FIXED_FREQ_CLOCK     <= sync_q[SY_FIXED];          // R4 R8
            O_LOW_POWER_OSC_CLOCK  <= sync_q[SY_LPO];            // R9
            O_CRYSTAL_OSC_OUTPUT   <= sync_q[SY_XOSC];           // R10
            O_TIMER_EXT_CLOCK      <= sync_q[SY_TIMER_PIN];      // R11
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            sel_req_q <= clk_src_e'(CTRL_RST_VAL[CTRL_SEL_LSB +: 2]);
            irq_pu_q  <= CTRL_RST_VAL[CTRL_IRQ_PU];
            irq_fn_q  <= CTRL_RST_VAL[CTRL_IRQ_FN];
        end else if (I_WR && I_ADDR == ADDR_CTRL) begin
            sel_req_q <= clk_src_e'(I_WDATA[CTRL_SEL_LSB +: 2]);
            irq_pu_q  <= I_WDATA[CTRL_IRQ_PU];
            irq_fn_q  <= I_WDATA[CTRL_IRQ_FN];
        end
    end

    // reset-pin enable: set once, cleared only by power-on or low-voltage reset
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            rst_pin_en_q <= 1'b0;                                // R16
        end else if (I_LVD_RESET) begin
            rst_pin_en_q <= 1'b0;                                // R16
        end else if (I_WR && I_ADDR == ADDR_PIN_OPT && I_WDATA[PIN_OPT_RST_EN]) begin
            rst_pin_en_q <= 1'b1;                                // R16
        end
    end

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    assign req_pin   = (state_q == RS_RUN) && rst_pin_en_q && !sync_q[SY_RSTPIN];
    assign req_force = I_WR && I_ADDR == ADDR_FORCE && I_WDATA[FORCE_BIT]
                       && I_DEBUG_CMD_ACTIVE && (state_q == RS_RUN);
    assign req_any   = (state_q == RS_RUN)
                       && (I_LVD_RESET || req_pin || req_force || I_INTERNAL_RESET_REQ);

    // holdoff ignores our own pulse still crossing the pin synchroniser
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            RS_POR: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == 8'(POR_SETTLE_CYC - 1)) begin
                    state_d = RS_RUN;
                    cnt_d   = 8'h00;
                end
            end
            RS_RUN: begin
                if (req_any) begin
                    state_d = RS_PULSE;                          // R17
                    cnt_d   = 8'h00;
                end
            end
            RS_PULSE: begin
                if (bus_tick) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == 8'(RST_PULSE_CYC - 1)) begin
                        state_d = RS_HOLDOFF;                    // R17
                        cnt_d   = 8'h00;
                    end
                end
            end
            RS_HOLDOFF: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == 8'(PIN_HOLDOFF_CYC - 1)) begin
                    state_d = RS_RUN;
                    cnt_d   = 8'h00;
                end
            end
            default: begin
                state_d = RS_POR;
                cnt_d   = 8'h00;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            state_q <= RS_POR;
            cnt_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // cause and debug mode; only the causes of the newest reset stay set
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            cause_q <= 5'h01;
            bdm_q   <= 1'b0;
        end else if (state_q == RS_POR && state_d == RS_RUN) begin
            bdm_q <= ~sync_q[SY_MODE];                           // R13
        end else if (req_any) begin
            cause_q                 <= 5'h00;
            cause_q[CAUSE_LVD]      <= I_LVD_RESET;              // R17
            cause_q[CAUSE_PIN]      <= req_pin;
            cause_q[CAUSE_FORCE]    <= req_force;
            cause_q[CAUSE_INTERNAL] <= I_INTERNAL_RESET_REQ;
            bdm_q <= req_force && !I_LVD_RESET && !req_pin && !sync_q[SY_MODE]; // R12 R13
        end
    end

    // ----------------------------------------------------------------
    // pin and reset outputs
    // ----------------------------------------------------------------
    // pin only ever pulls low; the pullup restores it
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            O_PORT_A_BIT_FIVE_O     <= 1'b0;
            O_PORT_A_BIT_FIVE_OE    <= 1'b0;
            O_RESET_PULLUP_EN       <= 1'b0;
            O_IRQ_PULLUP_EN         <= 1'b0;
            O_GPIO_IN               <= 1'b1;
            O_BACKGROUND_DEBUG_MODE <= 1'b0;
            O_SYS_RESET_N           <= 1'b0;
        end else begin
            O_PORT_A_BIT_FIVE_O     <= 1'b0;                     // R14
            // low-voltage reset drops the pin function on this edge: no stray drive
            O_PORT_A_BIT_FIVE_OE    <= (state_d == RS_PULSE) && rst_pin_en_q // R14 R17
                                       && !I_LVD_RESET;          // R16
            O_RESET_PULLUP_EN       <= rst_pin_en_q;             // R14
            O_IRQ_PULLUP_EN         <= !rst_pin_en_q && irq_fn_q && irq_pu_q; // R15
            O_GPIO_IN               <= sync_q[SY_RSTPIN];        // R16
            O_BACKGROUND_DEBUG_MODE <= bdm_q;
            O_SYS_RESET_N           <= (state_d == RS_RUN) || (state_d == RS_HOLDOFF);
        end
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    // data stand for exactly one cycle; unmapped addresses read zero
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN || !I_RD) begin
            O_RDATA <= 8'h00;
        end else begin
            case (I_ADDR)
                ADDR_CTRL:     O_RDATA <= {4'h0, irq_fn_q, irq_pu_q, sel_req_q};
                ADDR_PIN_OPT:  O_RDATA <= {7'h00, rst_pin_en_q};
                ADDR_RST_STAT: O_RDATA <= {3'h0, cause_q};       // R17
                ADDR_CLK_STAT: O_RDATA <= {4'h0, state_q == RS_PULSE, bdm_q, sel_q};
                default:       O_RDATA <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // helper: bus ticks seen inside the pulse
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN || state_q != RS_PULSE) begin
            hcnt_q <= 8'h00;
        end else if (bus_tick) begin
            hcnt_q <= hcnt_q + 8'h01;
        end
    end

    a_bus_halves_core: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R1
        core_rise |=> bus_q != $past(bus_q)) else $error("bus clock missed a core edge");

    a_bus_edge_aligned: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R18
        bus_q != $past(bus_q) |-> $past(core_rise)) else $error("bus clock moved off core edge");

    a_switch_while_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R2
        sel_q != $past(sel_q) |-> !$past(core_q) && sel_q != SRC_NONE)
        else $error("clock source switched while high");

    a_fixed_latency: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R4
        state_q == RS_RUN ##3 1'b1 |-> O_FIXED_FREQ_CLOCK == $past(I_FIXED_FREQ_PRESYNC, 3))
        else $error("fixed clock not three cycles behind its source");

    a_dbg_fast_gated: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R5
        sel_q == SRC_FLL |=> !O_DEBUG_FAST_CLOCK) else $error("debug fast clock on FLL");

    a_pin_no_debug: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R12
        req_pin |=> !bdm_q ##2 !O_BACKGROUND_DEBUG_MODE)
        else $error("pin reset entered debug mode");

    a_force_debug: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R13
        req_force && !I_LVD_RESET && !req_pin && !sync_q[SY_MODE]
        |=> bdm_q && cause_q[CAUSE_FORCE])
        else $error("forced reset missed debug mode");

    a_pulse_length: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R17
        state_q == RS_PULSE && state_d != RS_PULSE |-> hcnt_q == 8'(RST_PULSE_CYC - 1) && bus_tick)
        else $error("reset pulse length wrong");

    a_pin_en_sticky: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R16
        $fell(rst_pin_en_q) |-> $past(I_LVD_RESET)) else $error("reset-pin enable dropped");

    a_pullup_exclusive: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // R15
        O_RESET_PULLUP_EN |-> !O_IRQ_PULLUP_EN && !O_PORT_A_BIT_FIVE_O)
        else $error("pin pullup or drive wrong");

endmodule : system_clock_distribution

// ===== clock_dist_pkg.sv
// constants, field layouts and state codes for the chip clock and reset distribution block
// assumes one system clock; every clock source enters as an asynchronous level that is sampled
//
// What this block does
// R1: processor clock direct, bus clock halved
// R2: core clock from three selectable sources
// R3: all registers clocked by bus clock; this block's registers run on I_SYS_CLK instead
// R4: fixed clock synchronised; max half bus
// R5: debug fast clock only on reference modes
// R6: external reference offered to converter
// R7: internal reference offered to real-time counter
// R8: synchronised fixed clock offered to timers
// R9: low-power oscillator for counter and watchdog
// R10: crystal output offered to real-time counter
// R11: timer pin clock max quarter bus
// R12: reset pin never enters debug mode
// R13: mode pin low enters debug mode at power-on and forced reset
// R14: reset function: open-drain with pullup
// R15: interrupt function: optional software pullup
// R16: pin is input until enabled; sticky
// R17: non-power-on reset drives pin if enabled (not on low-voltage), records cause
// R18: glitch-free, phase-aligned bus clock switching
package clock_dist_pkg;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int             ADDR_W          = 8;
    localparam int             DATA_W          = 8;
    localparam logic [7:0]     ADDR_CTRL       = 8'h00;
    localparam logic [7:0]     ADDR_PIN_OPT    = 8'h01;
    localparam logic [7:0]     ADDR_FORCE      = 8'h02;
    localparam logic [7:0]     ADDR_RST_STAT   = 8'h03;
    localparam logic [7:0]     ADDR_CLK_STAT   = 8'h04;
    localparam logic [7:0]     CTRL_RST_VAL    = 8'h00;

    // field positions
    localparam int             CTRL_SEL_LSB    = 0;
    localparam int             CTRL_IRQ_PU     = 2;
    localparam int             CTRL_IRQ_FN     = 3;
    localparam int             PIN_OPT_RST_EN  = 0;
    localparam int             FORCE_BIT       = 0;
    localparam int             CAUSE_POR       = 0;
    localparam int             CAUSE_PIN       = 1;
    localparam int             CAUSE_FORCE     = 2;
    localparam int             CAUSE_INTERNAL  = 3;
    localparam int             CAUSE_LVD       = 4;

    // ----------------------------------------------------------------
    // synchroniser lanes
    // ----------------------------------------------------------------
    localparam int             NSYNC           = 10;
    localparam int             SY_FLL          = 0;
    localparam int             SY_INT_REF      = 1;
    localparam int             SY_EXT_REF      = 2;
    localparam int             SY_OSC          = 3;
    localparam int             SY_FIXED        = 4;
    localparam int             SY_LPO          = 5;
    localparam int             SY_XOSC         = 6;
    localparam int             SY_TIMER_PIN    = 7;
    localparam int             SY_MODE         = 8;
    localparam int             SY_RSTPIN       = 9;

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    localparam int             BUS_DIV         = 2;
    localparam int             DEBUG_FAST_MHZ  = 8;
    localparam int             RST_PULSE_BUS_CYC = 34;
    localparam int             POR_SETTLE_CYC  = 3;
    localparam int             PIN_HOLDOFF_CYC = 4;

    typedef enum logic [1:0] {
        SRC_FLL     = 2'b00,
        SRC_INT_REF = 2'b01,
        SRC_EXT_REF = 2'b10,
        SRC_NONE    = 2'b11
    } clk_src_e;

    typedef enum logic [1:0] {
        RS_POR      = 2'b00,
        RS_RUN      = 2'b01,
        RS_PULSE    = 2'b10,
        RS_HOLDOFF  = 2'b11
    } rst_state_e;

endpackage : clock_dist_pkg

// ===== system_clock_distribution_tb.sv
// testbench for system_clock_distribution: register bus, clock sources, pin wire
// assumes clock_dist_pkg; the bench drives every port itself, no partner model
`timescale 1ns/10ps
module system_clock_distribution_tb;
    import clock_dist_pkg::*;
    // ----------------------------------------------------------------
    // signals, source waveforms and instance
    // ----------------------------------------------------------------
    localparam int PULSE = 4; // short reset pulse keeps the run brief
    logic        clk, rstn, wr_en, rd_en, lvd, int_req, dbg_cmd, msel, ext_pin;
    logic [7:0]  addr, wdata, rdata, lfsr;
    logic        pin_o, pin_oe, rpu, ipu, core, bus, dfast, background_debug_mode, srst_n, pc, pb, pd;
    logic [6:0]  pass_out, pass_in, hist [$];
    logic [15:0] cnt;
    int          num_errors, total_checks, cyc, since, cr, br, dr, k;
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    // slow clocks from the counter and the lfsr; fixed and timer pin stay well under bus rate
    assign pass_in[5:0] = {cnt[7], lfsr[1], lfsr[0], cnt[6], cnt[3], cnt[4]};
    assign pass_in[6]   = (pin_oe & ~pin_o) ? 1'b0 : ext_pin; // open drain, pulled up
    system_clock_distribution #(.RST_PULSE_CYC(PULSE)) i_system_clock_distribution (
        .I_SYS_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_en),
        .I_RD(rd_en), .O_RDATA(rdata), .I_INT_REF_CLK(cnt[3]), .I_EXT_REF_CLK(cnt[4]),
        .I_FLL_CLK(cnt[2]), .I_CONTROLLED_OSCILLATOR(lfsr[2]),
        .I_FIXED_FREQ_PRESYNC(pass_in[2]), .I_LOW_POWER_OSC_CLOCK(pass_in[3]),
        .I_CRYSTAL_OSC_OUTPUT(pass_in[4]), .I_TIMER_EXT_CLOCK(pass_in[5]),
        .I_LVD_RESET(lvd), .I_INTERNAL_RESET_REQ(int_req), .I_DEBUG_CMD_ACTIVE(dbg_cmd),
        .I_MODE_SELECT_PIN(msel), .I_PORT_A_BIT_FIVE(pass_in[6]), .O_PORT_A_BIT_FIVE_O(pin_o),
        .O_PORT_A_BIT_FIVE_OE(pin_oe), .O_RESET_PULLUP_EN(rpu), .O_IRQ_PULLUP_EN(ipu),
        .O_GPIO_IN(pass_out[6]), .O_CORE_CLOCK_SOURCE(core), .O_PERIPHERAL_BUS_CLOCK(bus),
        .O_DEBUG_FAST_CLOCK(dfast), .O_EXT_REF_CLOCK_OUT(pass_out[0]),
        .O_INT_REF_CLOCK_OUT(pass_out[1]), .O_FIXED_FREQ_CLOCK(pass_out[2]),
        .O_LOW_POWER_OSC_CLOCK(pass_out[3]), .O_CRYSTAL_OSC_OUTPUT(pass_out[4]),
        .O_TIMER_EXT_CLOCK(pass_out[5]), .O_BACKGROUND_DEBUG_MODE(background_debug_mode), .O_SYS_RESET_N(srst_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // sources advance and the delay model samples on the same edge the design does
    always @(posedge clk) begin
        cnt <= cnt + 16'h0001;
        lfsr <= lfsr_next(lfsr);
        hist.push_front(pass_in);
        if (hist.size() > 3) hist.pop_back();
        since = rstn ? since + 1 : 0;
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            print_verdict();
        end
    end
    // every routed clock and the pin level lag their source by three cycles
    always @(negedge clk) begin
        if (since > 6) chk(pass_out, hist[2]);
        cr += (core & ~pc);
        br += (bus & ~pb);
        dr += (dfast & ~pd);
        {pc, pb, pd} = {core, bus, dfast};
    end
    // ----------------------------------------------------------------
    // bus tasks, checks and scenarios
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {wr_en, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {rd_en, addr} <= {1'b1, a};
        @(posedge clk) rd_en <= 1'b0;
        @(negedge clk) chk(rdata, e);
    endtask : rd
    // waits for the pin pulse, counts bus ticks inside it, then reads the cause
    task automatic pulse_check(input logic [7:0] cause, input logic dbg);
        int b0;
        k = 0;
        while (pin_oe !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        chk({srst_n, pin_o}, 2'b00);
        @(posedge clk) {int_req, ext_pin} <= 2'b01;
        b0 = br;
        while (pin_oe === 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        chk(br - b0 inside {PULSE - 1, PULSE}, 1'b1);
        repeat (30) @(posedge clk);
        rd(ADDR_RST_STAT, cause);
        chk(background_debug_mode, dbg);
    endtask : pulse_check
    task automatic print_verdict();
        $display("checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    initial begin
        {rstn, wr_en, rd_en, lvd, int_req, dbg_cmd, msel, ext_pin} = 8'h03;
        {addr, wdata, cnt, lfsr} = {16'h0000, 16'h0000, 8'h5f};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        rd(ADDR_RST_STAT, 8'h01);
        rd(ADDR_CTRL, CTRL_RST_VAL);
        rd(8'h7f, 8'h00);
        chk(background_debug_mode, 1'b0);
        // code 3 is kept but leaves the previous source running
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CTRL, 8'(s));
            repeat (120) @(posedge clk);
            {cr, br, dr} = 0;
            repeat (200) @(posedge clk);
            rd(ADDR_CTRL, 8'(s));
            rd(ADDR_CLK_STAT, (s == 3) ? 8'h02 : 8'(s));
            chk(br * 2 >= cr - 2 && br * 2 <= cr + 2 && cr > 4, 1'b1);
            chk(dr > 0, s != 0);
        end
        wr(ADDR_CTRL, 8'h0c);
        repeat (3) @(posedge clk);
        chk(ipu, 1'b1);
        wr(ADDR_CTRL, 8'h08);
        repeat (3) @(posedge clk);
        chk({ipu, rpu}, 2'b00);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_PIN_OPT, 8'h01);
        repeat (3) @(posedge clk);
        chk(rpu, 1'b1);
        wr(ADDR_PIN_OPT, 8'h00);
        rd(ADDR_PIN_OPT, 8'h01);
        @(posedge clk) int_req <= 1'b1;
        pulse_check(8'h08, 1'b0);
        @(posedge clk) {msel, ext_pin} <= 2'b00;
        pulse_check(8'h02, 1'b0);
        wr(ADDR_FORCE, 8'h01);
        repeat (20) @(posedge clk);
        rd(ADDR_RST_STAT, 8'h02);
        @(posedge clk) dbg_cmd <= 1'b1;
        wr(ADDR_FORCE, 8'h01);
        pulse_check(8'h04, 1'b1);
        chk(background_debug_mode, 1'b1);
        @(posedge clk) {dbg_cmd, msel, lvd} <= 3'b011;
        @(posedge clk) lvd <= 1'b0;
        repeat (400) @(posedge clk);
        rd(ADDR_RST_STAT, 8'h10);
        rd(ADDR_PIN_OPT, 8'h00);
        chk({rpu, background_debug_mode}, 2'b00);
        @(posedge clk) {rstn, msel} <= 2'b00;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        chk(background_debug_mode, 1'b1);
        print_verdict();
    end
endmodule : system_clock_distribution_tb
